// [pkg/clock_fallback_pkg.sv]
// Constants and types shared by the clock fallback control design
package clock_fallback_pkg;

    // Register byte offsets
    localparam logic [7:0] FALLBACK_SELECT_ADDR = 8'h00;
    localparam logic [7:0] MAIN_CLOCK_ADDR      = 8'h04;
    localparam logic [7:0] CLOCK_INPUT_ADDR     = 8'h08;
    localparam logic [7:0] CLOCK_ERROR_ADDR     = 8'h0c;
    localparam logic [7:0] MASTER_CONTROL_ADDR  = 8'h10;
    localparam logic [7:0] SYSTEM_ERROR_ADDR    = 8'h14;
    localparam logic [7:0] IRQ_MASK_ADDR        = 8'h18;

    // Reset values
    localparam logic [7:0] FALLBACK_SELECT_RST = 8'h00;
    localparam logic [2:0] MAIN_CLOCK_RST      = 3'h0;
    localparam logic [2:0] CLOCK_INPUT_RST     = 3'h3;
    localparam logic [1:0] IRQ_MASK_RST        = 2'h0;

    // Fallback select register fields
    localparam int ALT_RESOURCE_LSB = 6;
    localparam int FALLBACK_TYPE_LSB = 4;
    localparam int FORCE_FALLBACK_BIT = 3;
    localparam int FALLBACK_SOURCE_LSB = 0;

    // Clock input config fields
    localparam int FRAME_CLOCK_INPUT_BIT = 0;
    localparam int COMPAT_NORMAL_BIT     = 1;
    localparam int COMPAT_FALLBACK_BIT   = 2;

    // Master control and status fields
    localparam int CLEAR_ERRORS_BIT   = 0;
    localparam int SYSTEM_ERR_FALLBACK_BIT = 0;
    localparam int SYSTEM_ERR_CLOCK_BIT    = 1;

    // Clock error bits
    localparam int ERR_WIDTH    = 4;
    localparam int ERR_MAIN_BIT = 0;
    localparam int ERR_A_BIT    = 1;
    localparam int ERR_B_BIT    = 2;
    localparam int ERR_REF_BIT  = 3;

    // Fallback type codes
    typedef enum logic [1:0] {
        TYPE_TO_OSC_DIV4 = 2'h0,
        TYPE_DISABLED    = 2'h1,
        TYPE_TO_SOURCE   = 2'h2,
        TYPE_FROM_AB_BUS = 2'h3
    } fallback_type_type;

    // Clock source codes
    localparam logic [2:0] SRC_OSC_DIV4 = 3'h0;
    localparam logic [2:0] SRC_OSC      = 3'h1;
    localparam logic [2:0] SRC_A_CLOCKS = 3'h2;
    localparam logic [2:0] SRC_B_CLOCKS = 3'h3;
    localparam logic [2:0] SRC_NETREF   = 3'h4;
    localparam logic [2:0] SRC_LOCAL1   = 3'h5;
    localparam int         SOURCE_COUNT = 8;

    // Break-before-make gap of the source switch
    localparam int CLK_PERIOD_NS     = 20;
    localparam int SWITCH_GAP_NS     = 100;
    localparam int SWITCH_GAP_CYCLES = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [design/clock_source_switch.sv]
// Break-before-make one-hot clock source enable sequencer
`timescale 1ns/1ns
module clock_source_switch
    import clock_fallback_pkg::*;
#(
    parameter int GAP_CYCLES = SWITCH_GAP_CYCLES
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_b_in,
    // Requested source
    input  wire logic [2:0]              sel_in,
    // Source gate enables
    output logic [SOURCE_COUNT-1:0]      src_enable_out,
    output logic                         switching_out
);

    // The gap counter is eight bits wide
    if (GAP_CYCLES < 1 || GAP_CYCLES > 255) begin : g_bad_gap
        $error("GAP_CYCLES out of range");
    end

    typedef enum logic [1:0] {
        SW_STEADY = 2'b01,
        SW_QUIET  = 2'b10
    } switch_state_type;

    switch_state_type          state;
    switch_state_type          next_state;
    logic [2:0]                current;
    logic [2:0]                next_current;
    logic [7:0]                count;
    logic [7:0]                next_count;
    logic [SOURCE_COUNT-1:0]   decoded;
    logic [SOURCE_COUNT-1:0]   next_src_enable;

    // One-hot decode of the settled source
    for (genvar i = 0; i < SOURCE_COUNT; i++) begin : g_decode
        assign decoded[i] = (current == 3'(i));
    end

    // All gates stay closed for the gap so no runt pulse reaches the output
    always_comb begin
        next_state      = state;
        next_current    = current;
        next_count      = count;
        next_src_enable = src_enable_out;
        case (state)
            SW_STEADY: begin
                if (sel_in != current) begin
                    next_state      = SW_QUIET;
                    next_current    = sel_in;
                    next_count      = 8'(GAP_CYCLES);
                    next_src_enable = '0;
                end
            end
            SW_QUIET: begin
                next_src_enable = '0;
                if (count > 8'h01) begin
                    next_count = count - 8'h01;
                end else if (sel_in != current) begin
                    next_current = sel_in;
                    next_count   = 8'(GAP_CYCLES);
                end else begin
                    next_state      = SW_STEADY;
                    next_src_enable = decoded;
                end
            end
            default: begin
                next_state      = SW_QUIET;
                next_src_enable = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state          <= SW_STEADY;
            current        <= MAIN_CLOCK_RST;
            count          <= 8'h00;
            src_enable_out <= 8'h01;
            switching_out  <= 1'b0;
        end else begin
            state          <= next_state;
            current        <= next_current;
            count          <= next_count;
            src_enable_out <= next_src_enable;
            switching_out  <= (next_state == SW_QUIET);
        end
    end

    property p_break_before_make;
        @(posedge clk_in) disable iff (!rst_b_in)
        (src_enable_out != $past(src_enable_out)) && (src_enable_out != '0) |-> $past(src_enable_out) == '0;
    endproperty
    a_break_before_make: assert property (p_break_before_make) else $error("enable moved without gap");

endmodule // clock_source_switch

// [design/clock_fallback_control.sv]
// Clock fallback control with APB registers and interrupt
// How it works
// - Type 00: main failure selects oscillator/4
// - Type 01: automatic fallback disabled
// - Type 10: main failure selects secondary source
// - Type 11: A/B failure selects secondary
// - Frame select low means MC-1 pairing
// - Enabled error bit switches clocks over
// - Type 11 fallback disables bus clocks; any fallback takes compat from config bit 2
// - Fallback state sticks until software acts
// - Clearing errors via control clears fallback
// - System error bit records each failure-triggered fallback
// - Force bit forces secondary resources
// - Source selector bits 2-0, main codes
// - Codes: osc/4, osc, A, B, NETREF, locals
`timescale 1ns/1ns
module clock_fallback_control
    import clock_fallback_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    // APB slave
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [7:0]            paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic [31:0]                prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    // Failure flags from the clock monitors
    input  wire logic [ERR_WIDTH-1:0]  clock_fail_in,
    // Clock steering
    output logic [2:0]                 clock_source_sel_out,
    output logic [SOURCE_COUNT-1:0]    source_enable_out,
    output logic                       switching_out,
    output logic                       fallback_active_out,
    output logic                       ab_bus_clock_enable_out,
    output logic                       compat_clock_enable_out,
    output logic                       mc1_mode_out,
    // Interrupt
    output logic                       irq_out
);

    typedef enum logic [1:0] {
        FB_NORMAL = 2'b01,
        FB_FALLEN = 2'b10
    } fallback_state_type;

    // Reset release and failure synchronisers
    logic                  rst_meta;
    logic                  rst_b;
    logic [ERR_WIDTH-1:0]  fail_meta;
    logic [ERR_WIDTH-1:0]  fail_sync;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta <= 1'b0;
            rst_b    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_b    <= rst_meta;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            fail_meta <= '0;
            fail_sync <= '0;
        end else begin
            fail_meta <= clock_fail_in;
            fail_sync <= fail_meta;
        end
    end

    // Failure bits that may trigger for a given fallback type
    function automatic logic [ERR_WIDTH-1:0] enabled_errors(input logic [1:0] ftype);
        logic [ERR_WIDTH-1:0] m;
        m = '0;
        case (ftype)
            TYPE_TO_OSC_DIV4: m[ERR_MAIN_BIT] = 1'b1;
            TYPE_TO_SOURCE:   m[ERR_MAIN_BIT] = 1'b1;
            TYPE_FROM_AB_BUS: begin
                m[ERR_A_BIT] = 1'b1;
                m[ERR_B_BIT] = 1'b1;
            end
            default:         m = '0;
        endcase
        return m;
    endfunction

    // Registers
    logic [7:0]            fallback_select;
    logic [2:0]            main_clock_select;
    logic [2:0]            clock_input_config;
    logic [ERR_WIDTH-1:0]  clock_error;
    logic [1:0]            system_error;
    logic [1:0]            irq_mask;
    logic [7:0]            next_fallback_select;
    logic [2:0]            next_main_clock_select;
    logic [2:0]            next_clock_input_config;
    logic [ERR_WIDTH-1:0]  next_clock_error;
    logic [1:0]            next_system_error;
    logic [1:0]            next_irq_mask;
    logic [31:0]           next_prdata;
    logic                  next_pready;
    logic                  next_pslverr;
    logic                  wr_access;
    logic                  clear_errors;
    logic                  fallback_event;
    logic                  error_event;

    // Field views
    logic [1:0]            fallback_type_select;
    logic                  force_fallback;
    logic [2:0]            fallback_source_select;
    logic                  frame_clock_input_select;

    assign fallback_type_select     = fallback_select[FALLBACK_TYPE_LSB +: 2];
    assign force_fallback           = fallback_select[FORCE_FALLBACK_BIT];
    assign fallback_source_select   = fallback_select[FALLBACK_SOURCE_LSB +: 3];
    assign frame_clock_input_select = clock_input_config[FRAME_CLOCK_INPUT_BIT];
    assign wr_access                = psel_in && penable_in && pready_out && pwrite_in;
    assign clear_errors             = wr_access && (paddr_in == MASTER_CONTROL_ADDR)
                                      && pwdata_in[CLEAR_ERRORS_BIT];

    // Read data is fetched in the setup cycle so it can leave a flop
    always_comb begin
        next_fallback_select    = fallback_select;
        next_main_clock_select  = main_clock_select;
        next_clock_input_config = clock_input_config;
        next_irq_mask           = irq_mask;
        next_prdata             = prdata_out;
        next_pready             = psel_in && !penable_in;
        next_pslverr            = 1'b0;
        if (psel_in && !penable_in) begin
            next_prdata = 32'h0000_0000;
            case (paddr_in)
                FALLBACK_SELECT_ADDR: next_prdata[7:0]           = fallback_select;
                MAIN_CLOCK_ADDR:      next_prdata[2:0]           = main_clock_select;
                CLOCK_INPUT_ADDR:     next_prdata[2:0]           = clock_input_config;
                CLOCK_ERROR_ADDR:     next_prdata[ERR_WIDTH-1:0] = clock_error;
                MASTER_CONTROL_ADDR:  next_prdata                = 32'h0000_0000;
                SYSTEM_ERROR_ADDR:    next_prdata[1:0]           = system_error;
                IRQ_MASK_ADDR:        next_prdata[1:0]           = irq_mask;
                default:              next_pslverr               = 1'b1;
            endcase
        end
        if (wr_access) begin
            case (paddr_in)
                FALLBACK_SELECT_ADDR: next_fallback_select    = pwdata_in[7:0];
                MAIN_CLOCK_ADDR:      next_main_clock_select  = pwdata_in[2:0];
                CLOCK_INPUT_ADDR:     next_clock_input_config = pwdata_in[2:0];
                IRQ_MASK_ADDR:        next_irq_mask           = pwdata_in[1:0];
                default:              next_irq_mask           = irq_mask;
            endcase
        end
    end

    // Sticky flags: a new event in the clearing cycle survives
    always_comb begin
        next_clock_error  = (clear_errors ? '0 : clock_error) | fail_sync;
        next_system_error = system_error;
        if (wr_access && (paddr_in == SYSTEM_ERROR_ADDR)) begin
            next_system_error = system_error & ~pwdata_in[1:0];
        end
        if (fallback_event) begin
            next_system_error[SYSTEM_ERR_FALLBACK_BIT] = 1'b1;
        end
        if (error_event) begin
            next_system_error[SYSTEM_ERR_CLOCK_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            fallback_select    <= FALLBACK_SELECT_RST;
            main_clock_select  <= MAIN_CLOCK_RST;
            clock_input_config <= CLOCK_INPUT_RST;
            clock_error        <= '0;
            system_error       <= '0;
            irq_mask           <= IRQ_MASK_RST;
            prdata_out         <= 32'h0000_0000;
            pready_out         <= 1'b0;
            pslverr_out        <= 1'b0;
            irq_out            <= 1'b0;
        end else begin
            fallback_select    <= next_fallback_select;
            main_clock_select  <= next_main_clock_select;
            clock_input_config <= next_clock_input_config;
            clock_error        <= next_clock_error;
            system_error       <= next_system_error;
            irq_mask           <= next_irq_mask;
            prdata_out         <= next_prdata;
            pready_out         <= next_pready;
            pslverr_out        <= next_pslverr;
            irq_out            <= |(next_system_error & next_irq_mask);
        end
    end

    // Fallback state machine
    fallback_state_type  state;
    fallback_state_type  next_state;
    logic                trigger;
    logic                active;
    logic [2:0]          next_source;
    logic                next_ab_enable;
    logic                next_compat_enable;

    assign trigger     = |(clock_error & enabled_errors(fallback_type_select));
    assign error_event = |fail_sync & ~|clock_error;
    assign active      = (state == FB_FALLEN) || force_fallback;

    always_comb begin
        next_state     = state;
        fallback_event = 1'b0;
        case (state)
            FB_NORMAL: begin
                if (trigger && !clear_errors) begin
                    next_state     = FB_FALLEN;
                    fallback_event = 1'b1;
                end
            end
            FB_FALLEN: begin
                if (clear_errors) begin
                    next_state = FB_NORMAL;
                end
            end
            default: next_state = FB_NORMAL;
        endcase
    end

    // Source choice and clock gating on fallback
    always_comb begin
        next_source        = main_clock_select;
        next_ab_enable     = 1'b1;
        next_compat_enable = clock_input_config[COMPAT_NORMAL_BIT];
        if (active) begin
            if (fallback_type_select == TYPE_TO_OSC_DIV4 && !force_fallback) begin
                next_source = SRC_OSC_DIV4;
            end else begin
                next_source = fallback_source_select;
            end
            if (fallback_type_select == TYPE_FROM_AB_BUS) begin
                next_ab_enable = 1'b0;
            end
            next_compat_enable = clock_input_config[COMPAT_FALLBACK_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            state                   <= FB_NORMAL;
            clock_source_sel_out    <= MAIN_CLOCK_RST;
            fallback_active_out     <= 1'b0;
            ab_bus_clock_enable_out <= 1'b1;
            compat_clock_enable_out <= 1'b1;
            mc1_mode_out            <= 1'b0;
        end else begin
            state                   <= next_state;
            clock_source_sel_out    <= next_source;
            fallback_active_out     <= active;
            ab_bus_clock_enable_out <= next_ab_enable;
            compat_clock_enable_out <= next_compat_enable;
            mc1_mode_out            <= !frame_clock_input_select;
        end
    end

    // Gates follow the registered choice with a quiet gap
    clock_source_switch #(
        .GAP_CYCLES (SWITCH_GAP_CYCLES)
    ) u_switch (
        .clk_in         (clk_in),
        .rst_b_in       (rst_b),
        .sel_in         (clock_source_sel_out),
        .src_enable_out (source_enable_out),
        .switching_out  (switching_out)
    );

    property p_osc_div4;
        @(posedge clk_in) disable iff (!rst_b)
        (state == FB_FALLEN) && (fallback_type_select == TYPE_TO_OSC_DIV4) && !force_fallback
        |=> clock_source_sel_out == SRC_OSC_DIV4;
    endproperty
    a_osc_div4: assert property (p_osc_div4) else $error("type 00 not on osc/4");

    property p_disabled;
        @(posedge clk_in) disable iff (!rst_b)
        (state == FB_NORMAL) && (fallback_type_select == TYPE_DISABLED) |=> state == FB_NORMAL;
    endproperty
    a_disabled: assert property (p_disabled) else $error("fallback with type 01");

    property p_to_source;
        @(posedge clk_in) disable iff (!rst_b)
        (state == FB_FALLEN) && (fallback_type_select == TYPE_TO_SOURCE)
        |=> clock_source_sel_out == $past(fallback_source_select);
    endproperty
    a_to_source: assert property (p_to_source) else $error("secondary source not applied");

    property p_ab_off;
        @(posedge clk_in) disable iff (!rst_b)
        (state == FB_FALLEN) && (fallback_type_select == TYPE_FROM_AB_BUS)
        |=> !ab_bus_clock_enable_out && fallback_active_out;
    endproperty
    a_ab_off: assert property (p_ab_off) else $error("bus clocks left on");

    property p_mc1;
        @(posedge clk_in) disable iff (!rst_b)
        !frame_clock_input_select ##1 !frame_clock_input_select |-> mc1_mode_out;
    endproperty
    a_mc1: assert property (p_mc1) else $error("MC-1 mode not shown");

    property p_trigger;
        @(posedge clk_in) disable iff (!rst_b)
        (state == FB_NORMAL) && trigger && !clear_errors |=> (state == FB_FALLEN) ##1 fallback_active_out;
    endproperty
    a_trigger: assert property (p_trigger) else $error("failure did not fall back");

    property p_sticky;
        @(posedge clk_in) disable iff (!rst_b)
        (state == FB_FALLEN) && !clear_errors |=> state == FB_FALLEN;
    endproperty
    a_sticky: assert property (p_sticky) else $error("fallback reverted alone");

    property p_clear;
        @(posedge clk_in) disable iff (!rst_b)
        clear_errors |=> (state == FB_NORMAL) && (clock_error == $past(fail_sync));
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not release");

    property p_system_error_reg;
        @(posedge clk_in) disable iff (!rst_b)
        fallback_event |=> system_error[SYSTEM_ERR_FALLBACK_BIT];
    endproperty
    a_system_error_reg: assert property (p_system_error_reg) else $error("fallback not recorded");

    property p_force;
        @(posedge clk_in) disable iff (!rst_b)
        force_fallback |=> fallback_active_out && (clock_source_sel_out == $past(fallback_source_select));
    endproperty
    a_force: assert property (p_force) else $error("force bit ignored");

    property p_enabled_only;
        @(posedge clk_in) disable iff (!rst_b)
        (state == FB_NORMAL) && !(|(clock_error & enabled_errors(fallback_type_select))) |=> state == FB_NORMAL;
    endproperty
    a_enabled_only: assert property (p_enabled_only) else $error("fallback on disabled bit");

    property p_irq;
        @(posedge clk_in) disable iff (!rst_b)
        irq_out == |(system_error & irq_mask);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule // clock_fallback_control

// [tb/clock_fallback_control_tb.sv]
// Self-checking testbench for the clock fallback control block
`timescale 1ns/1ns
module clock_fallback_control_tb;
    import clock_fallback_pkg::*;
    logic                    clk_in;
    logic                    rst_b_in;
    logic                    psel_in;
    logic                    penable_in;
    logic                    pwrite_in;
    logic [7:0]              paddr_in;
    logic [31:0]             pwdata_in;
    logic [31:0]             prdata_out;
    logic                    pready_out;
    logic                    pslverr_out;
    logic [ERR_WIDTH-1:0]    clock_fail_in;
    logic [2:0]              clock_source_sel_out;
    logic [SOURCE_COUNT-1:0] source_enable_out;
    logic                    switching_out;
    logic                    fallback_active_out;
    logic                    ab_bus_clock_enable_out;
    logic                    compat_clock_enable_out;
    logic                    mc1_mode_out;
    logic                    irq_out;
    int                      n_fail;
    int                      cmp_count;
    logic [31:0]             rd;
    logic                    err;

    clock_fallback_control u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .clock_fail_in(clock_fail_in), .clock_source_sel_out(clock_source_sel_out),
        .source_enable_out(source_enable_out), .switching_out(switching_out),
        .fallback_active_out(fallback_active_out), .ab_bus_clock_enable_out(ab_bus_clock_enable_out),
        .compat_clock_enable_out(compat_clock_enable_out), .mc1_mode_out(mc1_mode_out), .irq_out(irq_out));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Outputs are read right after an edge, so they hold their settled pre-edge values
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (pready_out !== 1'b1 && i < 50);
        if (i >= 50) begin
            n_fail++;
            $display("CHECK FAILED at %0t: no ready", $time);
            report_and_stop();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // Program a mode, raise failures, check the steering, then clear through the control register
    task automatic fail_case(input logic [7:0] fsel, input logic [3:0] f, input logic [2:0] sel,
                             input logic act, input logic ab);
        apb(1'b1, FALLBACK_SELECT_ADDR, {24'h0, fsel});
        cycles(12);
        clock_fail_in <= f;
        cycles(16);
        check(clock_source_sel_out, sel);
        check(fallback_active_out, act);
        check(ab_bus_clock_enable_out, ab);
        check(source_enable_out, 8'h01 << sel);
        clock_fail_in <= 4'h0;
        apb(1'b1, MASTER_CONTROL_ADDR, 32'h1);
        cycles(12);
    endtask

    initial begin
        n_fail = 0;
        cmp_count = 0;
        rst_b_in = 1'b0;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        clock_fail_in = 4'h0;
        cycles(8);
        rst_b_in <= 1'b1;
        cycles(3);
        apb(1'b0, FALLBACK_SELECT_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, CLOCK_INPUT_ADDR, 32'h0);
        check(rd, 32'h3);
        apb(1'b0, 8'h1c, 32'h0);
        check(err, 1'b1);
        check(mc1_mode_out, 1'b0);
        apb(1'b1, MAIN_CLOCK_ADDR, 32'h2);
        apb(1'b1, CLOCK_INPUT_ADDR, 32'h4);
        cycles(12);
        check(mc1_mode_out, 1'b1);
        check(compat_clock_enable_out, 1'b0);
        check(source_enable_out, 8'h04);
        // Type 00 with a non-zero source field still lands on oscillator/4
        apb(1'b1, FALLBACK_SELECT_ADDR, 32'h03);
        clock_fail_in <= 4'h1;
        cycles(16);
        check(clock_source_sel_out, 3'h0);
        check(fallback_active_out, 1'b1);
        check(compat_clock_enable_out, 1'b1);
        check(irq_out, 1'b0);
        apb(1'b0, SYSTEM_ERROR_ADDR, 32'h0);
        check(rd[0], 1'b1);
        apb(1'b1, IRQ_MASK_ADDR, 32'h1);
        cycles(3);
        check(irq_out, 1'b1);
        clock_fail_in <= 4'h0;
        cycles(12);
        check(fallback_active_out, 1'b1);
        check(clock_source_sel_out, 3'h0);
        apb(1'b1, MASTER_CONTROL_ADDR, 32'h1);
        cycles(12);
        check(fallback_active_out, 1'b0);
        check(clock_source_sel_out, 3'h2);
        apb(1'b1, SYSTEM_ERROR_ADDR, 32'h3);
        cycles(3);
        check(irq_out, 1'b0);
        fail_case(8'h10, 4'h1, 3'h2, 1'b0, 1'b1);
        fail_case(8'h24, 4'h1, 3'h4, 1'b1, 1'b1);
        fail_case(8'h35, 4'h1, 3'h2, 1'b0, 1'b1);
        fail_case(8'h35, 4'h2, 3'h5, 1'b1, 1'b0);
        fail_case(8'h37, 4'h4, 3'h7, 1'b1, 1'b0);
        fail_case(8'h21, 4'h8, 3'h2, 1'b0, 1'b1);
        // Force bit with automatic fallback off; the gap must show all gates closed
        apb(1'b1, FALLBACK_SELECT_ADDR, 32'h1b);
        for (int i = 0; i < 20 && switching_out !== 1'b1; i++) @(posedge clk_in);
        check(switching_out, 1'b1);
        check(source_enable_out, 8'h00);
        cycles(12);
        check(fallback_active_out, 1'b1);
        check(clock_source_sel_out, 3'h3);
        check(source_enable_out, 8'h08);
        apb(1'b1, FALLBACK_SELECT_ADDR, 32'h10);
        cycles(12);
        check(fallback_active_out, 1'b0);
        check(clock_source_sel_out, 3'h2);
        report_and_stop();
    end
endmodule // clock_fallback_control_tb
